// >>> io_access_controller.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Core-side controller: software orders accesses over AXI4-Lite
module io_access_controller
  import io_space_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  io_bus_if.core bus,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic {H_IDLE, H_WAIT} hostState_t;
  hostState_t stateQ; // Idle or waiting for the answer
  logic wrTake; // Address and data accepted together
  logic cmdHit; // Accepted write lands on the command register
  logic startOk; // Command passes the local checks
  opKind_t newKind; // Kind field of the incoming command
  logic [7:0] dataAddr; // Data address of the incoming command
  logic legal; // Address valid for the kind
  logic isWrite; // Command stores something
  logic isBitOp; // Command names one bit
  logic [7:0] keepMask; // Bits that may carry a one
  logic reqValidQ, doneQ, skipQ, errQ; // Status flops
  logic [7:0] rdataQ; // Last read value
  opKind_t kindQ; // Request kind held for the bus
  logic [7:0] addrQ, dataQ; // Request address and data held for the bus
  logic [2:0] bitQ; // Request bit held for the bus
  logic bvalidQ, rvalidQ; // Response valids
  logic [1:0] brespQ, rrespQ; // Response codes
  logic [31:0] rdataAxiQ; // Read payload

  assign newKind = opKind_t'(s_axi_wdata[CMD_KIND_LSB +: 4]);
  io_addr_map mapper (
    .kind(newKind),
    .addr(s_axi_wdata[CMD_ADDR_LSB +: 8]),
    .dataAddr(dataAddr),
    .legal(legal),
    .isWrite(isWrite),
    .isBitOp(isBitOp)
  );

  // Address and data are taken together; one write response at a time
  assign wrTake = s_axi_awvalid && s_axi_wvalid && !bvalidQ;
  assign s_axi_awready = wrTake;
  assign s_axi_wready = wrTake;
  assign cmdHit = wrTake && (s_axi_awaddr == CMD_OFFSET) && (stateQ == H_IDLE);
  assign keepMask = rwMask(dataAddr) | w1cMask(dataAddr);
  // Stores to unmapped addresses and out-of-range addresses never go out
  assign startOk = legal && !(isWrite && !isBitOp && keepMask == 8'h00);

  // Request state machine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stateQ <= H_IDLE;
      reqValidQ <= 1'b0;
    end else begin
      case (stateQ)
        H_IDLE: begin
          if (cmdHit && startOk) begin
            stateQ <= H_WAIT;
            reqValidQ <= 1'b1;
          end
        end
        H_WAIT: begin
          // Drop the request as soon as its answer is seen
          if (bus.done) begin
            stateQ <= H_IDLE;
            reqValidQ <= 1'b0;
          end
        end
        default: stateQ <= H_IDLE;
      endcase
    end
  end

  // Request payload held steady while valid is high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      kindQ <= io_read_op;
      addrQ <= 8'h00;
      bitQ <= 3'h0;
      dataQ <= 8'h00;
    end else if (cmdHit && startOk) begin
      kindQ <= newKind;
      addrQ <= s_axi_wdata[CMD_ADDR_LSB +: 8];
      bitQ <= s_axi_wdata[CMD_BIT_LSB +: 3];
      // Reserved bits always go out as zero
      dataQ <= s_axi_wdata[CMD_DATA_LSB +: 8] & keepMask;
    end
  end

  // Status: a new command clears done, a refused one reports at once
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      doneQ <= 1'b0;
      skipQ <= 1'b0;
      errQ <= 1'b0;
      rdataQ <= 8'h00;
    end else if (stateQ == H_WAIT && bus.done) begin
      doneQ <= 1'b1;
      skipQ <= bus.skip;
      errQ <= bus.err;
      rdataQ <= bus.rdata;
    end else if (cmdHit) begin
      doneQ <= !startOk;
      errQ <= !startOk;
      skipQ <= 1'b0;
      rdataQ <= 8'h00;
    end
  end

  // Write response; command writes while busy are answered with an error
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bvalidQ <= 1'b0;
      brespQ <= RESP_OKAY;
    end else if (wrTake) begin
      bvalidQ <= 1'b1;
      brespQ <= cmdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalidQ <= 1'b0;
    end
  end

  // Read channel; unmapped offsets read zero with an error
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rvalidQ <= 1'b0;
      rrespQ <= RESP_OKAY;
      rdataAxiQ <= 32'h0;
    end else if (s_axi_arvalid && !rvalidQ) begin
      rvalidQ <= 1'b1;
      if (s_axi_araddr == STATUS_OFFSET) begin
        rrespQ <= RESP_OKAY;
        rdataAxiQ <= {16'h0, rdataQ, 4'h0, errQ, skipQ, doneQ, reqValidQ};
      end else begin
        rrespQ <= RESP_SLVERR;
        rdataAxiQ <= 32'h0;
      end
    end else if (s_axi_rready) begin
      rvalidQ <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalidQ;
  assign s_axi_bvalid = bvalidQ;
  assign s_axi_bresp = brespQ;
  assign s_axi_rvalid = rvalidQ;
  assign s_axi_rresp = rrespQ;
  assign s_axi_rdata = rdataAxiQ;
  assign bus.reqValid = reqValidQ;
  assign bus.reqKind = kindQ;
  assign bus.reqAddr = addrQ;
  assign bus.reqBit = bitQ;
  assign bus.reqData = dataQ;
endmodule : io_access_controller
`default_nettype wire

// >>> io_addr_map.sv
`timescale 1ns/1ns
`default_nettype none
// Maps an access kind and its address onto the data address space
module io_addr_map
  import io_space_pkg::*;
(
  input wire opKind_t kind,
  input wire logic [7:0] addr,
  output logic [7:0] dataAddr,
  output logic legal,
  output logic isWrite,
  output logic isBitOp
);
  always_comb begin
    dataAddr = addr;
    legal = 1'b0;
    isWrite = 1'b0;
    isBitOp = 1'b0;
    case (kind)
      // Six-bit I/O address seen at its data address plus 32
      io_read_op, io_write_op: begin
        legal = (addr <= IO_TOP);
        dataAddr = 8'(addr + IO_SPACE_OFFSET);
        isWrite = (kind == io_write_op);
      end
      // Bit operations exist for the low 32 locations only
      set_io_bit_op, clear_io_bit_op, skip_if_io_bit_set_op, skip_if_io_bit_clear_op: begin
        legal = (addr <= BIT_OP_TOP);
        dataAddr = 8'(addr + IO_SPACE_OFFSET);
        isBitOp = 1'b1;
        isWrite = (kind == set_io_bit_op) || (kind == clear_io_bit_op);
      end
      // Loads and stores reach both I/O and extended space
      default: begin
        legal = (addr >= IO_SPACE_OFFSET) && (addr <= EXT_HIGH);
        isWrite = (kind == data_store_op) || (kind == direct_data_store_op);
      end
    endcase
  end
endmodule : io_addr_map
`default_nettype wire

// >>> io_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
// Request/answer path between the core-side controller and the register bank
interface io_bus_if;
  import io_space_pkg::*;
  logic reqValid; // Held high until done is seen
  opKind_t reqKind; // Access kind
  logic [7:0] reqAddr; // I/O address or data address, by kind
  logic [2:0] reqBit; // Bit number for bit operations
  logic [7:0] reqData; // Write data
  logic done; // One-cycle answer pulse
  logic [7:0] rdata; // Read value, valid with done
  logic skip; // Tested bit condition met, valid with done
  logic err; // Request refused, valid with done

  modport core (output reqValid, reqKind, reqAddr, reqBit, reqData,
                input done, rdata, skip, err);
  modport periph (input reqValid, reqKind, reqAddr, reqBit, reqData,
                  output done, rdata, skip, err);
endinterface : io_bus_if
`default_nettype wire

// >>> io_register_bank.sv
`timescale 1ns/1ns
`default_nettype none
// Peripheral register bank answering the core over io_bus_if
module io_register_bank
  import io_space_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  io_bus_if.periph bus,
  // Flag events from the peripherals, one-cycle pulses
  input wire logic [7:0] lowFlagSet,
  input wire logic [2:0] usiFlagSet,
  input wire logic [3:0] busFlagSet,
  // Live peripheral state shown in read-only bits
  input wire logic usiCountDone,
  input wire logic [7:0] usiBuffered,
  input wire logic [2:0] busIdState,
  input wire logic busBusy,
  input wire logic [7:0] busErrors,
  // Stored settings driven out to the peripherals
  output logic [7:0] usiControl,
  output logic [7:0] busControl,
  output logic [7:0] lowFlags,
  output logic [NVM_TOP_BIT:0] nvmAddr
);
  logic [7:0] regQ [256]; // One byte per data address
  logic [7:0] mapAddr; // Data address of the current request
  logic legal; // Address valid for this kind
  logic isWrite; // Request stores something
  logic isBitOp; // Request names a single bit
  logic take; // Request accepted this cycle
  logic [7:0] readVal; // Value seen at mapAddr
  logic [7:0] bitSel; // One-hot bit of the request
  logic testBit; // Addressed bit for the skip tests
  logic doneQ; // Answer pulse
  logic [7:0] rdataQ; // Answered read value
  logic skipQ; // Answered skip condition
  logic errQ; // Answered refusal

  io_addr_map mapper (
    .kind(bus.reqKind),
    .addr(bus.reqAddr),
    .dataAddr(mapAddr),
    .legal(legal),
    .isWrite(isWrite),
    .isBitOp(isBitOp)
  );

  // Live bits merged into reads
  function automatic logic [7:0] liveBits(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == USI_STATUS_COUNTER) begin
      v = {3'h0, usiCountDone, 4'h0};
    end else if (a == USI_BUFFERED_DATA) begin
      v = usiBuffered;
    end else if (a == SERIAL_BUS_STATUS_INTERRUPT) begin
      v = {busIdState, busBusy, 4'h0};
    end else if (a == SERIAL_BUS_ERROR) begin
      v = busErrors;
    end
    return v & roMask(a);
  endfunction : liveBits

  // Hardware events that raise flag bits at each location
  function automatic logic [7:0] flagEvents(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == LOW_FLAGS_ADDR) begin
      v = lowFlagSet;
    end else if (a == USI_STATUS_COUNTER) begin
      v = {usiFlagSet, 5'h00};
    end else if (a == SERIAL_BUS_STATUS_INTERRUPT) begin
      v = {4'h0, busFlagSet};
    end
    return v & w1cMask(a);
  endfunction : flagEvents

  // Readback: stored bits under their masks, then live bits
  function automatic logic [7:0] readBack(input logic [7:0] a, input logic [7:0] stored);
    // Unmapped locations have all masks zero and so read zero
    return (stored & (rwMask(a) | w1cMask(a))) | liveBits(a);
  endfunction : readBack

  // A request is taken once; the cycle of its answer is skipped
  assign take = bus.reqValid && !doneQ;
  // Tracks live inputs read in functions
  always_comb readVal = readBack(mapAddr, regQ[mapAddr]);
  assign bitSel = 8'h01 << bus.reqBit;
  assign testBit = |(readVal & bitSel);

  // One storage cell per data address
  for (genvar g = 0; g < 256; g++) begin : gCell
    localparam logic [7:0] A = 8'(g);
    logic hit; // This cell is addressed by an accepted write
    logic [7:0] clr; // Flag bits cleared by this access
    logic [7:0] rwNew; // Plain bits after this access
    always_comb begin
      hit = take && legal && isWrite && (mapAddr == A);
      clr = 8'h00;
      rwNew = regQ[g];
      if (hit && !isBitOp) begin
        // Whole-byte write: a one clears a flag, a zero leaves it
        clr = bus.reqData & w1cMask(A);
        rwNew = (regQ[g] & ~rwMask(A)) | (bus.reqData & rwMask(A));
      end else if (hit && bus.reqKind == set_io_bit_op) begin
        // Only the named bit moves; neighbouring flags are untouched
        clr = bitSel & w1cMask(A);
        rwNew = regQ[g] | bitSel;
      end else if (hit) begin
        // Clearing writes a zero, which never clears a flag
        rwNew = regQ[g] & ~bitSel;
      end
    end

    // Storage update; a flag event in the clear cycle still sets it
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        regQ[g] <= REG_RESET;
      end else begin
        regQ[g] <= (rwNew & rwMask(A)) | (regQ[g] & w1cMask(A) & ~clr)
                   | flagEvents(A);
      end
    end
  end

  // Answer pulse, one cycle after the request is taken
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      doneQ <= 1'b0;
    end else begin
      doneQ <= take;
    end
  end

  // Answer payload, captured with the pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdataQ <= 8'h00;
      skipQ <= 1'b0;
      errQ <= 1'b0;
    end else if (take) begin
      // Refused requests answer with zero data and no side effect
      errQ <= !legal;
      rdataQ <= (legal && !isWrite && !isBitOp) ? readVal : 8'h00;
      if (legal && bus.reqKind == skip_if_io_bit_set_op) begin
        skipQ <= testBit;
      end else if (legal && bus.reqKind == skip_if_io_bit_clear_op) begin
        skipQ <= !testBit;
      end else begin
        skipQ <= 1'b0;
      end
    end
  end

  assign bus.done = doneQ;
  assign bus.rdata = rdataQ;
  assign bus.skip = skipQ;
  assign bus.err = errQ;

  // Settings to the peripherals come straight from storage flops
  assign usiControl = regQ[USI_CONTROL];
  assign busControl = regQ[SERIAL_BUS_CONTROL];
  assign lowFlags = regQ[LOW_FLAGS_ADDR];
  // Bits above the top address bit are never stored, so they cannot leak
  assign nvmAddr = {regQ[NVM_ADDR_HIGH][NVM_TOP_BIT - 8:0], regQ[NVM_ADDR_LOW]};
endmodule : io_register_bank
`default_nettype wire

// >>> io_space_pkg.sv
// Contract
// - Low 32 I/O registers: bit set, clear, test-skip
// - Status flags clear on written one only
// - Bit set/clear touches only the addressed bit
// - Bit operations only for I/O addresses 0..31
// - I/O instructions use addresses 0..63 directly
// - Data-space view adds 32 to I/O address
// - Extended space 96..255 reached only by load/store
// - NVM address bits above top bit ignored
// - Software writes zero to reserved bits
// - Software never writes reserved addresses
`default_nettype none
package io_space_pkg;
  // Access kinds the core can issue
  typedef enum logic [3:0] {
    io_read_op, io_write_op, set_io_bit_op, clear_io_bit_op,
    skip_if_io_bit_set_op, skip_if_io_bit_clear_op,
    data_load_op, data_store_op, direct_data_load_op, direct_data_store_op
  } opKind_t;

  // Address map limits
  localparam logic [7:0] IO_SPACE_OFFSET = 8'h20;
  localparam logic [7:0] BIT_OP_TOP = 8'h1f;
  localparam logic [7:0] IO_TOP = 8'h3f;
  localparam logic [7:0] EXT_LOW = 8'h60;
  localparam logic [7:0] EXT_HIGH = 8'hff;
  // Low-space locations with special behaviour (data addresses)
  localparam logic [7:0] LOW_FLAGS_ADDR = 8'h3c;
  localparam logic [7:0] NVM_ADDR_LOW = 8'h41;
  localparam logic [7:0] NVM_ADDR_HIGH = 8'h42;
  // Highest implemented NVM address bit, so the high byte keeps one bit
  localparam int NVM_TOP_BIT = 8;
  localparam logic [7:0] NVM_HIGH_MASK = 8'((16'h2 << (NVM_TOP_BIT - 8)) - 16'h1);
  // Extended registers
  localparam logic [7:0] USI_CONTROL = 8'hb8;
  localparam logic [7:0] USI_STATUS_COUNTER = 8'hb9;
  localparam logic [7:0] USI_SHIFT_DATA = 8'hba;
  localparam logic [7:0] USI_BUFFERED_DATA = 8'hbb;
  localparam logic [7:0] USI_PIN_POSITION = 8'hbc;
  localparam logic [7:0] SERIAL_BUS_CONTROL = 8'hc8;
  localparam logic [7:0] SERIAL_BUS_STATUS_INTERRUPT = 8'hc9;
  localparam logic [7:0] SERIAL_BUS_INTERRUPT_ENABLE = 8'hca;
  localparam logic [7:0] SERIAL_BUS_ERROR = 8'hcb;
  localparam logic [7:0] SERIAL_BUS_BIT_TIMING = 8'hcc;
  localparam logic [7:0] SERIAL_BUS_DIVISOR_LOW = 8'hcd;
  localparam logic [7:0] SERIAL_BUS_DIVISOR_HIGH = 8'hce;
  localparam logic [7:0] SERIAL_BUS_DATA_LENGTH = 8'hcf;
  localparam logic [7:0] SERIAL_BUS_IDENTIFIER = 8'hd0;
  localparam logic [7:0] SERIAL_BUS_BUFFER_SELECT = 8'hd1;
  localparam logic [7:0] SERIAL_BUS_DATA_BUFFER = 8'hd2;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Controller register map and fields
  localparam logic [3:0] CMD_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_BIT_LSB = 8;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CMD_KIND_LSB = 24;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_SKIP = 2;
  localparam int ST_ERR = 3;
  localparam int ST_RDATA_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bits software may write as plain storage
  function automatic logic [7:0] rwMask(input logic [7:0] a);
    if (a >= IO_SPACE_OFFSET && a <= 8'h5f && a != LOW_FLAGS_ADDR)
      return (a == NVM_ADDR_HIGH) ? NVM_HIGH_MASK : 8'hff;
    else if (a == USI_CONTROL || a == USI_SHIFT_DATA) return 8'hff;
    else if (a == USI_STATUS_COUNTER) return 8'h0f;
    else if (a == USI_PIN_POSITION) return 8'h01;
    else if (a == SERIAL_BUS_CONTROL || a == SERIAL_BUS_DIVISOR_LOW) return 8'hff;
    else if (a == SERIAL_BUS_INTERRUPT_ENABLE) return 8'h0f;
    else if (a == SERIAL_BUS_BIT_TIMING) return 8'hbf;
    else if (a == SERIAL_BUS_DIVISOR_HIGH || a == SERIAL_BUS_BUFFER_SELECT) return 8'h0f;
    else if (a >= SERIAL_BUS_DATA_LENGTH && a <= SERIAL_BUS_DATA_BUFFER) return 8'hff;
    else return 8'h00;
  endfunction : rwMask

  // Flag bits that hardware sets and a written one clears
  function automatic logic [7:0] w1cMask(input logic [7:0] a);
    if (a == LOW_FLAGS_ADDR) return 8'hff;
    else if (a == USI_STATUS_COUNTER) return 8'he0;
    else if (a == SERIAL_BUS_STATUS_INTERRUPT) return 8'h0f;
    else return 8'h00;
  endfunction : w1cMask

  // Bits that show live peripheral state
  function automatic logic [7:0] roMask(input logic [7:0] a);
    if (a == USI_STATUS_COUNTER) return 8'h10;
    else if (a == USI_BUFFERED_DATA || a == SERIAL_BUS_ERROR) return 8'hff;
    else if (a == SERIAL_BUS_STATUS_INTERRUPT) return 8'hf0;
    else return 8'h00;
  endfunction : roMask
endpackage : io_space_pkg
`default_nettype wire

// >>> io_space_register_decode_bench.sv
`timescale 1ns/1ns
`default_nettype none
// Both ends joined, ordered over AXI4-Lite
module io_space_register_decode_bench
  import io_space_pkg::*;
;
  typedef struct {opKind_t k; logic [7:0] a; logic [2:0] b; logic [7:0] d; logic [7:0] r;
    logic s; logic e;} row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // Peripheral events and live state
  logic [7:0] lowSet = 8'h00;
  logic [2:0] usiSet = 3'h0;
  logic [3:0] busSet = 4'h0;
  logic usiCountDone = 1'b1;
  logic [7:0] usiBuffered = 8'h5a;
  logic [2:0] busIdState = 3'h5;
  logic busBusy = 1'b1;
  logic [7:0] busErrors = 8'hc3;
  logic [7:0] usiControl, busControl, lowFlags;
  logic [NVM_TOP_BIT:0] nvmAddr;
  int badCount = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] st;
  logic [1:0] resp;
  // Rows: kind, address, bit, data, read value, skip, refused
  row_t rows [0:34] = '{
    '{io_write_op,8'h1f,0,8'ha5,0,0,0}, '{data_load_op,8'h3f,0,0,8'ha5,0,0},
    '{direct_data_store_op,8'h25,0,8'h3c,0,0,0}, '{io_read_op,8'h05,0,0,8'h3c,0,0},
    '{set_io_bit_op,8'h05,0,0,0,0,0}, '{clear_io_bit_op,8'h05,2,0,0,0,0},
    '{data_load_op,8'h25,0,0,8'h39,0,0}, '{skip_if_io_bit_set_op,8'h05,0,0,0,1,0},
    '{skip_if_io_bit_clear_op,8'h05,0,0,0,0,0}, '{skip_if_io_bit_clear_op,8'h05,1,0,0,1,0},
    '{set_io_bit_op,8'h20,0,0,0,0,1}, '{io_read_op,8'h40,0,0,0,0,1},
    '{data_load_op,8'h1f,0,0,0,0,1}, '{data_store_op,8'hcd,0,8'h77,0,0,0},
    '{direct_data_load_op,8'hcd,0,0,8'h77,0,0}, '{data_store_op,8'hce,0,8'hff,0,0,0},
    '{data_load_op,8'hce,0,0,8'h0f,0,0}, '{data_load_op,8'hd3,0,0,8'h00,0,0},
    '{data_store_op,8'h41,0,8'hff,0,0,0}, '{data_store_op,8'h42,0,8'hff,0,0,0},
    '{data_load_op,8'h42,0,0,8'h01,0,0}, '{data_load_op,8'hbb,0,0,8'h5a,0,0},
    '{data_load_op,8'hcb,0,0,8'hc3,0,0}, '{io_read_op,8'h1c,0,0,8'h81,0,0},
    '{io_write_op,8'h1c,0,8'h01,0,0,0}, '{io_write_op,8'h1c,0,8'h00,0,0,0},
    '{io_read_op,8'h1c,0,0,8'h80,0,0}, '{data_load_op,8'hc9,0,0,8'hb5,0,0},
    '{data_store_op,8'hc9,0,8'h01,0,0,0}, '{data_load_op,8'hc9,0,0,8'hb4,0,0},
    '{data_load_op,8'hb9,0,0,8'hf0,0,0}, '{data_store_op,8'hb9,0,8'he3,0,0,0},
    '{data_load_op,8'hb9,0,0,8'h13,0,0}, '{data_store_op,8'hb8,0,8'h3c,0,0,0},
    '{data_store_op,8'hc8,0,8'h81,0,0,0}};
  io_bus_if i_io_bus_if();
  io_access_controller i_io_access_controller (.ref_clk, .rst,
    .bus(i_io_bus_if), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  io_register_bank i_io_register_bank (.ref_clk, .rst, .bus(i_io_bus_if),
    .lowFlagSet(lowSet), .usiFlagSet(usiSet), .busFlagSet(busSet), .usiCountDone,
    .usiBuffered, .busIdState, .busBusy, .busErrors, .usiControl, .busControl, .lowFlags,
    .nvmAddr);
  io_space_register_decode_properties i_io_space_register_decode_properties (
    .ref_clk, .rst, .reqValid(i_io_bus_if.reqValid),
    .reqKind(i_io_bus_if.reqKind), .reqAddr(i_io_bus_if.reqAddr),
    .reqBit(i_io_bus_if.reqBit), .reqData(i_io_bus_if.reqData), .done(i_io_bus_if.done),
    .rdata(i_io_bus_if.rdata), .skip(i_io_bus_if.skip), .err(i_io_bus_if.err));
  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;
  // Hang guard, far above a full run
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      badCount = badCount + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      badCount = badCount + 1;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // Address and data offered together, held until taken
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge ref_clk); while (awready !== 1'b1 || wready !== 1'b1);
    @(posedge ref_clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge ref_clk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge ref_clk);
    bready <= 1'b0;
  endtask : axiWr
  task automatic axiRd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge ref_clk); while (arready !== 1'b1);
    @(posedge ref_clk);
    arvalid <= 1'b0;
    do @(negedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge ref_clk);
    rready <= 1'b0;
  endtask : axiRd
  // One access; poll status until it lands
  task automatic runRow(input row_t w);
    axiWr(CMD_OFFSET, {4'h0, w.k, w.a, 5'h00, w.b, w.d}, resp);
    check(32'(resp), 32'(RESP_OKAY), "cmd resp");
    st = 32'h1;
    while (st[ST_BUSY] !== 1'b0 || st[ST_DONE] !== 1'b1) axiRd(STATUS_OFFSET, st, resp);
    check(32'(st[ST_ERR]), 32'(w.e), "refused");
    check(32'(st[ST_SKIP]), 32'(w.s), "skip");
    if (w.k inside {io_read_op, data_load_op, direct_data_load_op})
      check(32'(st[15:8]), 32'(w.r), "read data");
  endtask : runRow
  // Flag events, one cycle each
  task automatic pulse(input logic [7:0] l, input logic [2:0] u, input logic [3:0] b);
    @(posedge ref_clk);
    lowSet <= l;
    usiSet <= u;
    busSet <= b;
    @(posedge ref_clk);
    lowSet <= 8'h00;
    usiSet <= 3'h0;
    busSet <= 4'h0;
  endtask : pulse
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check(32'(lowFlags), 32'h0, "flags reset");
    check(32'(nvmAddr), 32'h0, "nvm after reset");
    pulse(8'h81, 3'h7, 4'h5);
    foreach (rows[i]) begin
      runRow(rows[i]);
      $display("row %0d done", i);
    end
    check(32'(nvmAddr), 32'h1ff, "nvm address");
    check(32'(usiControl), 32'h3c, "usi control");
    check(32'(busControl), 32'h81, "bus control");
    check(32'(lowFlags), 32'h80, "flags out");
    // Bit ops keep a pending neighbour flag
    pulse(8'h01, 3'h0, 4'h0);
    runRow('{set_io_bit_op, 8'h1c, 0, 0, 0, 0, 0});
    runRow('{clear_io_bit_op, 8'h1c, 7, 0, 0, 0, 0});
    runRow('{io_read_op, 8'h1c, 0, 0, 8'h80, 0, 0});
    $display("bit op test done");
    // Unmapped read offset and a write to the status offset refused
    axiRd(4'h8, st, resp);
    check(32'(resp), 32'(RESP_SLVERR), "read refused");
    check(st, 32'h0, "refused data");
    axiWr(4'h4, 32'h0, resp);
    check(32'(resp), 32'(RESP_SLVERR), "write refused");
    $display("refusal test done");
    // Mid-run reset
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check(32'(lowFlags), 32'h0, "flags 2nd reset");
    check(32'(usiControl), 32'h0, "control 2nd reset");
    runRow('{io_read_op, 8'h1f, 0, 0, 8'h00, 0, 0});
    $display("reset test done");
    report_and_stop();
  end
endmodule : io_space_register_decode_bench
`default_nettype wire

// >>> io_space_register_decode_properties.sv
`timescale 1ns/1ns
`default_nettype none
// Checks on the core-to-bank request path
module io_space_register_decode_properties
  import io_space_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire opKind_t reqKind,
  input wire logic [7:0] reqAddr,
  input wire logic [2:0] reqBit,
  input wire logic [7:0] reqData,
  input wire logic done,
  input wire logic [7:0] rdata,
  input wire logic skip,
  input wire logic err
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Taken when no answer stands in that cycle
  logic take, isBit, isIo, isLs;
  assign take = reqValid && !done;
  assign isBit = reqKind inside {[set_io_bit_op:skip_if_io_bit_clear_op]};
  assign isIo = reqKind inside {io_read_op, io_write_op};
  assign isLs = reqKind inside {[data_load_op:direct_data_store_op]};
  property p_answer; take |=> done; endproperty
  a_answer: assert property (p_answer) else $error("answer late");
  property p_pulse; done |=> !done; endproperty
  a_pulse: assert property (p_pulse) else $error("answer too long");
  property p_hold; take |=> reqValid && $stable(reqAddr) && $stable(reqKind); endproperty
  a_hold: assert property (p_hold) else $error("request not held");
  property p_bit_high; reqValid && isBit |-> reqAddr <= BIT_OP_TOP; endproperty
  a_bit_high: assert property (p_bit_high) else $error("bit op above 0x1f");
  property p_bit_ok; take && isBit && reqAddr <= BIT_OP_TOP |=> !err; endproperty
  a_bit_ok: assert property (p_bit_ok) else $error("low bit op refused");
  property p_io_high; reqValid && isIo |-> reqAddr <= IO_TOP; endproperty
  a_io_high: assert property (p_io_high) else $error("io op above 0x3f");
  property p_ls_low; reqValid && isLs |-> reqAddr >= IO_SPACE_OFFSET; endproperty
  a_ls_low: assert property (p_ls_low) else $error("load/store below 0x20");
  property p_ext_ok; take && isLs && reqAddr >= EXT_LOW |=> !err; endproperty
  a_ext_ok: assert property (p_ext_ok) else $error("ext access refused");
  property p_err_zero;
    take && isLs && reqAddr > SERIAL_BUS_DATA_BUFFER |=> rdata == 8'h00;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("reserved read not zero");
  property p_skip_kind;
    done && skip |-> reqKind inside {skip_if_io_bit_set_op, skip_if_io_bit_clear_op};
  endproperty
  a_skip_kind: assert property (p_skip_kind) else $error("skip from a non-test op");
  // Main scenarios reached
  c_skip: cover property (done && skip);
  c_bitop: cover property (take && isBit);
  c_store: cover property (take && reqKind == data_store_op);
endmodule : io_space_register_decode_properties
`default_nettype wire
